// ---- dv/i2ccr_master_model.sv ----
// Serial bus master model: drives the clock line and pulls the data line low.
// Assumes the bench resolves the data line as a wired AND with a pull-up.
module i2ccr_master_model #(
  parameter int QTR = 8
) (
  // Clock
  input wire logic clock_in,
  // Bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // Each step waits a third of a bit, samples the data line, then moves both lines.
  task automatic step(input logic scl, input logic pull, output logic smp);
    repeat (QTR) @(posedge clock_in);
    smp = sda_in;
    scl_out <= scl;
    sda_pull_out <= pull;
  endtask : step
  // Data changes only a third of a bit after the clock falls, so the slave never sees
  // both lines move in the same synchroniser cycle.
  task automatic bit_io(input logic b, output logic r);
    logic t;
    step(1'b0, ~b, t);
    step(1'b1, ~b, t);
    step(1'b0, ~b, r);
  endtask : bit_io
  task automatic start();
    logic t;
    step(scl_out, 1'b0, t);
    step(1'b1, 1'b0, t);
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask : start
  task automatic stop();
    logic t;
    step(1'b0, 1'b1, t);
    step(1'b1, 1'b1, t);
    step(1'b1, 1'b0, t);
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send
  task automatic recv(input logic ackm, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ackm, r);
  endtask : recv
endmodule : i2ccr_master_model

// ---- dv/tb_i2ccr_top.sv ----
// Self-checking bench for the serial bus configuration register slave.
// Assumes the master model in its own file; the data line has a pull-up.
module tb_i2ccr_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SADR = 7'h2a;
  // Arbitrary identity value.
  localparam logic [7:0] IDV = 8'h5a;
  localparam logic [7:0] CUR [16] = '{8'h06, 8'h0e, 8'h17, 8'h20, 8'h2a, 8'h33, 8'h3d,
    8'h46, 8'h4f, 8'h59, 8'h64, 8'h6e, 8'h78, 8'h82, 8'h8c, 8'h96};
  logic clock_in;
  logic rst_n_in;
  logic scl;
  logic pull;
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic [3:0] ovc;
  logic [3:0] pcc;
  logic [1:0] hlc;
  logic [1:0] clc;
  logic [9:0] ov10;
  logic [7:0] pc10;
  logic [6:0] ht;
  logic [6:0] ct;
  logic ack;
  logic [23:0] rb;
  logic [3:0] vc;
  logic [7:0] nv;
  int fails;
  int num_checks;
  int seed;
  assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;
  i2ccr_top #(.SLAVE_ADDR(SADR), .ID_CODE(IDV)) dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .out_volt_code_out(ovc), .peak_current_code_out(pcc), .hot_limit_code_out(hlc),
    .cold_limit_code_out(clc), .out_volt_10mv_out(ov10), .peak_current_10ma_out(pc10),
    .hot_trip_degc_out(ht), .cold_trip_degc_out(ct));
  i2ccr_master_model u_m (.clock_in(clock_in), .sda_in(sda), .scl_out(scl),
    .sda_pull_out(pull));
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  task automatic close_out();
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [9:0] ev(input logic [3:0] c);
    return (c <= 4'ha) ? 10'h1a4 + 10'h014 * c : 10'h1f4;
  endfunction : ev
  // Compares both the raw fields and the decoded settings against one setting.
  task automatic chk_out(input logic [7:0] cv, input logic [7:0] tv);
    repeat (3) @(posedge clock_in);
    chk("conv", cv, {ovc, pcc});
    chk("ntc", tv, {2'h0, hlc, 2'h0, clc});
    chk("volt", ev(cv[7:4]), ov10);
    chk("cur", CUR[cv[3:0]], pc10);
    chk("hot", 7'h37 + 7'h05 * tv[5:4], ht);
    chk("cold", 7'h05 * tv[1:0], ct);
  endtask : chk_out
  // The auto-increment read-back runs on to pointer 1Bh, which is unmapped and reads as zero.
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d0,
      input logic [7:0] d1, input int n, output logic ok);
    logic k;
    u_m.start();
    u_m.send({a, 1'b0}, ok);
    // The result is high only if the address, command and every data byte were acked.
    if (ok) begin
      u_m.send(cmd, k);
      ok = ok & k;
      if (n > 0) u_m.send(d0, k);
      ok = ok & k;
      if (n > 1) u_m.send(d1, k);
      ok = ok & k;
    end
    u_m.stop();
  endtask : wr
  task automatic rd(input logic [7:0] cmd, input int n, output logic [23:0] q);
    logic k;
    logic [7:0] b;
    q = 24'h0;
    u_m.start();
    u_m.send({SADR, 1'b0}, k);
    u_m.send(cmd, k);
    u_m.start();
    u_m.send({SADR, 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      u_m.recv(i < n - 1, b);
      q = {q[15:0], b};
    end
    u_m.stop();
  endtask : rd
  initial begin
    #2.5ms;
    fails++;
    close_out();
  end
  initial begin
    seed = 8;
    fails = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    chk_out(8'h4b, 8'h11);
    rd(8'h1f, 2, rb);
    chk("id", {IDV, IDV}, rb[15:0]);
    for (int i = 0; i < 16; i++) begin
      vc = 4'(i);
      nv = 8'($random(seed)) & 8'h33;
      wr(SADR, 8'h99, {vc, ~vc}, nv, 2, ack);
      chk("ack", 1'b1, ack);
      chk_out({vc, ~vc}, nv);
      rd(8'h99, 3, rb);
      chk("rdback", {vc, ~vc, nv, 8'h00}, rb);
    end
    wr(SADR ^ 7'h01, 8'h19, 8'h00, 8'h00, 1, ack);
    chk("foreign_ack", 1'b0, ack);
    wr(SADR, 8'h1f, 8'h00, 8'h00, 1, ack);
    chk("id_wr_ack", 1'b1, ack);
    wr(SADR, 8'h1a, 8'h22, 8'h30, 2, ack);
    chk_out(8'hf0, 8'h30);
    wr(SADR, 8'h1a, 8'h03, 8'h00, 1, ack);
    chk("ntc_ack", 1'b1, ack);
    chk_out(8'hf0, 8'h03);
    rd(8'h1f, 1, rb);
    chk("id_kept", IDV, rb[7:0]);
    // A reset in mid-run must bring back the defaults and leave the bus usable.
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    chk_out(8'h4b, 8'h11);
    rd(8'h19, 1, rb);
    chk("conv_rst", 8'h4b, rb[7:0]);
    close_out();
  end
endmodule : tb_i2ccr_top

// ---- verilog/i2ccr_pkg.sv ----
// Constants for the bus slave configuration register block.
// Assumes a single system clock; the bus master supplies the serial clock.
package i2ccr_pkg;
  // Register pointers; command bit 7 carries the auto-increment flag.
  localparam logic [6:0] ADDR_CONV = 7'h19;
  localparam logic [6:0] ADDR_NTC = 7'h1a;
  localparam logic [6:0] ADDR_ID = 7'h1f;
  localparam int CMD_AUTO_BIT = 7;
  localparam logic [7:0] CONV_RST = 8'h4b;
  localparam logic [7:0] NTC_RST = 8'h11;
  localparam logic [7:0] NTC_MASK = 8'h33;
  // Field positions.
  localparam int VOLT_MSB = 7;
  localparam int VOLT_LSB = 4;
  localparam int CUR_MSB = 3;
  localparam int CUR_LSB = 0;
  localparam int HOT_MSB = 5;
  localparam int HOT_LSB = 4;
  localparam int COLD_MSB = 1;
  localparam int COLD_LSB = 0;
  // Output voltage decode in units of 10 mV.
  localparam logic [3:0] VOLT_CODE_MAX = 4'ha;
  localparam logic [9:0] VOLT_BASE = 10'h1a4;
  localparam logic [9:0] VOLT_STEP = 10'h014;
  localparam logic [9:0] VOLT_DFLT = 10'h1f4;
  // Peak current limit in units of 10 mA, indexed by code.
  localparam logic [7:0] CUR_TBL [16] = '{8'h06, 8'h0e, 8'h17, 8'h20,
    8'h2a, 8'h33, 8'h3d, 8'h46, 8'h4f, 8'h59, 8'h64, 8'h6e, 8'h78,
    8'h82, 8'h8c, 8'h96};
  // Thermistor trip levels in degrees Celsius.
  localparam logic [6:0] HOT_BASE = 7'h37;
  localparam logic [6:0] COLD_BASE = 7'h00;
  localparam logic [6:0] TRIP_STEP = 7'h05;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } i2ccr_state_e;
endpackage : i2ccr_pkg

// ---- verilog/i2ccr_top.sv ----
// Serial bus slave holding the converter, thermistor and identity registers.
// Assumes scl_in and sda_in come straight from pins; sda is open drain.
// Functional notes
// - Converter register 19h: voltage and current codes
// - Current code decodes sixteen limits, reset 1.1 A
// - Codes 0-10 step 0.2 V; others 5 V
// - Thermistor register 1Ah: hot 5:4, cold 1:0
// - Hot codes map to 55..70 degrees
// - Cold codes map to 0..15 degrees
// - Fixed identity code readable at 1Fh
// - Write: address, command byte, then stored data
// - Auto-increment advances pointer per acknowledged write
// - Read: command write, repeated start, then data
// - Read increments on master ack only if auto
// - Next read byte loads on ack clock rise
// - Reads unlimited; master nack ends the read
module i2ccr_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a,
  // Arbitrary identity value.
  parameter logic [7:0] ID_CODE = 8'h5a
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Raw register fields
  output logic [3:0] out_volt_code_out,
  output logic [3:0] peak_current_code_out,
  output logic [1:0] hot_limit_code_out,
  output logic [1:0] cold_limit_code_out,
  // Decoded settings
  output logic [9:0] out_volt_10mv_out,
  output logic [7:0] peak_current_10ma_out,
  output logic [6:0] hot_trip_degc_out,
  output logic [6:0] cold_trip_degc_out
);
  // Stage 0 is read only by stage 1; stages 1 and 2 feed the edge logic.
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic scl_rise, scl_fall, start_seen, stop_seen, sda_bit;
  i2ccr_pkg::i2ccr_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, conv_q, conv_d, ntc_q, ntc_d;
  logic [6:0] ptr_q, ptr_d, ptr_inc;
  logic auto_q, auto_d, rw_q, rw_d, oe_q, oe_d;
  logic [9:0] volt_q, volt_d;
  logic [7:0] cur_q, cur_d;
  logic [6:0] hot_q, hot_d, cold_q, cold_d;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  assign sda_bit = sda_q[1];
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_seen = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_seen = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign ptr_inc = ptr_q + {6'h00, auto_q};

  // Unmapped pointers read as zero; undefined thermistor bits read as zero.
  function automatic logic [7:0] rd_mux(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == i2ccr_pkg::ADDR_CONV) v = conv_q;
    else if (a == i2ccr_pkg::ADDR_NTC) v = ntc_q;
    else if (a == i2ccr_pkg::ADDR_ID) v = ID_CODE;
    return v;
  endfunction : rd_mux

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    auto_d = auto_q;
    rw_d = rw_q;
    conv_d = conv_q;
    ntc_d = ntc_q;
    // A start is honoured in any state, which also gives the repeated start.
    if (start_seen) begin
      st_d = i2ccr_pkg::ST_ADDR;
      cnt_d = 4'h0;
    end else if (stop_seen) begin
      st_d = i2ccr_pkg::ST_IDLE;
      cnt_d = 4'h0;
    end else if (scl_rise) begin
      unique case (st_q)
        i2ccr_pkg::ST_ADDR, i2ccr_pkg::ST_CMD, i2ccr_pkg::ST_WDATA: begin
          sh_d = {sh_q[6:0], sda_bit};
          cnt_d = cnt_q + 4'h1;
        end
        i2ccr_pkg::ST_RDATA: cnt_d = cnt_q + 4'h1;
        i2ccr_pkg::ST_ADDR_ACK: begin
          if (rw_q) tx_d = rd_mux(ptr_q);
        end
        i2ccr_pkg::ST_RDATA_ACK: begin
          if (sda_bit) begin
            st_d = i2ccr_pkg::ST_IDLE;
          end else begin
            ptr_d = ptr_inc;
            tx_d = rd_mux(ptr_inc);
          end
        end
        i2ccr_pkg::ST_IDLE, i2ccr_pkg::ST_CMD_ACK, i2ccr_pkg::ST_WDATA_ACK: ;
      endcase
    end else if (scl_fall) begin
      unique case (st_q)
        i2ccr_pkg::ST_ADDR: begin
          if (cnt_q == i2ccr_pkg::BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            if (sh_q[7:1] == SLAVE_ADDR) begin
              rw_d = sh_q[0];
              st_d = i2ccr_pkg::ST_ADDR_ACK;
            end else begin
              st_d = i2ccr_pkg::ST_IDLE;
            end
          end
        end
        i2ccr_pkg::ST_CMD: begin
          if (cnt_q == i2ccr_pkg::BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            ptr_d = sh_q[6:0];
            auto_d = sh_q[i2ccr_pkg::CMD_AUTO_BIT];
            st_d = i2ccr_pkg::ST_CMD_ACK;
          end
        end
        i2ccr_pkg::ST_WDATA: begin
          if (cnt_q == i2ccr_pkg::BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            st_d = i2ccr_pkg::ST_WDATA_ACK;
            // Identity and reserved pointers accept the byte and drop it.
            if (ptr_q == i2ccr_pkg::ADDR_CONV) conv_d = sh_q;
            if (ptr_q == i2ccr_pkg::ADDR_NTC) ntc_d = sh_q & i2ccr_pkg::NTC_MASK;
          end
        end
        i2ccr_pkg::ST_RDATA: begin
          if (cnt_q == i2ccr_pkg::BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            st_d = i2ccr_pkg::ST_RDATA_ACK;
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
          end
        end
        i2ccr_pkg::ST_ADDR_ACK: st_d = rw_q ? i2ccr_pkg::ST_RDATA : i2ccr_pkg::ST_CMD;
        i2ccr_pkg::ST_CMD_ACK: st_d = i2ccr_pkg::ST_WDATA;
        i2ccr_pkg::ST_WDATA_ACK: begin
          ptr_d = ptr_inc;
          st_d = i2ccr_pkg::ST_WDATA;
        end
        i2ccr_pkg::ST_RDATA_ACK: st_d = i2ccr_pkg::ST_RDATA;
        i2ccr_pkg::ST_IDLE: ;
      endcase
    end
    // Pull the line low for our acknowledges and for zero data bits.
    oe_d = (st_d == i2ccr_pkg::ST_ADDR_ACK) || (st_d == i2ccr_pkg::ST_CMD_ACK) ||
           (st_d == i2ccr_pkg::ST_WDATA_ACK) ||
           ((st_d == i2ccr_pkg::ST_RDATA) && !tx_d[7]);
  end

  always_comb begin
    logic [3:0] vc;
    vc = conv_q[i2ccr_pkg::VOLT_MSB:i2ccr_pkg::VOLT_LSB];
    if (vc > i2ccr_pkg::VOLT_CODE_MAX) volt_d = i2ccr_pkg::VOLT_DFLT;
    else volt_d = i2ccr_pkg::VOLT_BASE + i2ccr_pkg::VOLT_STEP * {6'h00, vc};
    cur_d = i2ccr_pkg::CUR_TBL[conv_q[i2ccr_pkg::CUR_MSB:i2ccr_pkg::CUR_LSB]];
    hot_d = i2ccr_pkg::HOT_BASE + i2ccr_pkg::TRIP_STEP *
            {5'h00, ntc_q[i2ccr_pkg::HOT_MSB:i2ccr_pkg::HOT_LSB]};
    cold_d = i2ccr_pkg::COLD_BASE + i2ccr_pkg::TRIP_STEP *
             {5'h00, ntc_q[i2ccr_pkg::COLD_MSB:i2ccr_pkg::COLD_LSB]};
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= i2ccr_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 7'h00;
      auto_q <= 1'b0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      conv_q <= i2ccr_pkg::CONV_RST;
      ntc_q <= i2ccr_pkg::NTC_RST;
      volt_q <= i2ccr_pkg::VOLT_DFLT;
      cur_q <= i2ccr_pkg::CUR_TBL[i2ccr_pkg::CONV_RST[3:0]];
      // Both thermistor fields reset to code one, one step above the base.
      hot_q <= i2ccr_pkg::HOT_BASE + i2ccr_pkg::TRIP_STEP;
      cold_q <= i2ccr_pkg::COLD_BASE + i2ccr_pkg::TRIP_STEP;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      auto_q <= auto_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      conv_q <= conv_d;
      ntc_q <= ntc_d;
      volt_q <= volt_d;
      cur_q <= cur_d;
      hot_q <= hot_d;
      cold_q <= cold_d;
    end
  end

  // The pin value is always low; only the enable moves.
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_q;
  assign out_volt_code_out = conv_q[i2ccr_pkg::VOLT_MSB:i2ccr_pkg::VOLT_LSB];
  assign peak_current_code_out = conv_q[i2ccr_pkg::CUR_MSB:i2ccr_pkg::CUR_LSB];
  assign hot_limit_code_out = ntc_q[i2ccr_pkg::HOT_MSB:i2ccr_pkg::HOT_LSB];
  assign cold_limit_code_out = ntc_q[i2ccr_pkg::COLD_MSB:i2ccr_pkg::COLD_LSB];
  assign out_volt_10mv_out = volt_q;
  assign peak_current_10ma_out = cur_q;
  assign hot_trip_degc_out = hot_q;
  assign cold_trip_degc_out = cold_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  logic wr_fire, rack_rise, byte_fall;
  assign byte_fall = scl_fall && !start_seen && !stop_seen && cnt_q == i2ccr_pkg::BITS_PER_BYTE;
  assign wr_fire = byte_fall && st_q == i2ccr_pkg::ST_WDATA;
  assign rack_rise = scl_rise && !start_seen && !stop_seen && st_q == i2ccr_pkg::ST_RDATA_ACK;

  sequence s_master_ack;
    rack_rise && !sda_bit;
  endsequence
  sequence s_master_nack;
    rack_rise && sda_bit;
  endsequence
  sequence s_own_addr;
    byte_fall && st_q == i2ccr_pkg::ST_ADDR && sh_q[7:1] == SLAVE_ADDR;
  endsequence

  property p_conv_wr;
    wr_fire && ptr_q == i2ccr_pkg::ADDR_CONV |=> conv_q == $past(sh_q) ##1
      out_volt_code_out == $past(sh_q, 2) >> 4;
  endproperty
  a_conv_wr: assert property (p_conv_wr) else $error("converter write lost");
  property p_cur;
    conv_q[3:0] == 4'hb |=> peak_current_10ma_out == 8'h6e;
  endproperty
  a_cur: assert property (p_cur) else $error("current decode wrong");
  property p_volt;
    conv_q[7:4] > 4'ha |=> out_volt_10mv_out == 10'h1f4;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage default wrong");
  property p_ntc_undef;
    wr_fire && ptr_q == i2ccr_pkg::ADDR_NTC |=> (ntc_q & 8'hcc) == 8'h00 &&
      ntc_q[5:4] == $past(sh_q[5:4]);
  endproperty
  a_ntc_undef: assert property (p_ntc_undef) else $error("thermistor write wrong");
  property p_hot;
    ntc_q[5:4] == 2'h0 && ntc_q[1:0] == 2'h3 |=> hot_trip_degc_out == 7'h37 &&
      cold_trip_degc_out == 7'h0f;
  endproperty
  a_hot: assert property (p_hot) else $error("trip decode wrong");
  property p_winc;
    scl_fall && !start_seen && !stop_seen && st_q == i2ccr_pkg::ST_WDATA_ACK && auto_q
      |=> ptr_q == $past(ptr_q) + 7'h01;
  endproperty
  a_winc: assert property (p_winc) else $error("write pointer not advanced");
  property p_rhold;
    s_master_ack and !auto_q |=> ptr_q == $past(ptr_q) && tx_q == rd_mux(ptr_q);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read pointer moved");
  property p_nack;
    s_master_nack |=> st_q == i2ccr_pkg::ST_IDLE && !sda_oe_out;
  endproperty
  a_nack: assert property (p_nack) else $error("nack did not end read");
  property p_foreign;
    byte_fall && st_q == i2ccr_pkg::ST_ADDR && sh_q[7:1] != SLAVE_ADDR
      |=> !sda_oe_out [*2];
  endproperty
  a_foreign: assert property (p_foreign) else $error("answered foreign address");
  property p_own_ack;
    s_own_addr |=> sda_oe_out ##1 sda_oe_out;
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("own address not acknowledged");
  property p_wack;
    wr_fire |=> sda_oe_out;
  endproperty
  a_wack: assert property (p_wack) else $error("data byte not acknowledged");
  property p_rload;
    scl_rise && !start_seen && !stop_seen && st_q == i2ccr_pkg::ST_ADDR_ACK && rw_q
      |=> tx_q == rd_mux(ptr_q);
  endproperty
  a_rload: assert property (p_rload) else $error("first read byte not loaded");
  property p_rinc;
    s_master_ack and auto_q |=> ptr_q == $past(ptr_q) + 7'h01 && tx_q == rd_mux(ptr_q);
  endproperty
  a_rinc: assert property (p_rinc) else $error("read pointer not advanced");
endmodule : i2ccr_top
